// [verilog/adf_ctrl.sv]
// adf_ctrl: adc decimation filter control, registers on ahb-lite
// assumes: one clock hclk; modulator bits and demod samples on hclk
//
// Summary of operation
// - global enable low holds filters, demod reset
// - clear then set global enable realigns filters
// - bits 14,13,12 route external pins to filters
// - crystal clock and halves drive out pins
// - each new output sample raises interrupt request
// - decimation-by-6 filter takes 18-bit input samples
// - bit 9 swaps filter 2 and 3 inputs
// - bits 8:7 pick decimation-by-6 input source
// - bits 4:3 set stereo factor 32..256
// - bits 6:5 set mono factor 32..256
// - bit 2 enables decimation-by-6 filter
// - bit 1 mono enable, bit 0 stereo
// - filters sample at crystal divided by two
// - ad outputs read as high word plus low byte, dec6 as high word plus low 2 bits
// - both config registers read/write, reset zero
//
// The implementer's own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module adf_ctrl #(
  parameter int XTAL_DIV = 2 // hclk cycles per crystal half period
) (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic [31:0]               hrdata,
  output logic                      hresp,
  // internal modulator bits
  input  wire logic                 mod_bit_left,
  input  wire logic                 mod_bit_right,
  input  wire logic                 third_line_input,
  // external converter pins
  input  wire logic                 ext_digital_in_left,
  input  wire logic                 ext_digital_in_right,
  input  wire logic                 ext_digital_in_mono,
  // demodulator
  input  wire adf_pkg::adf_dec6_in_s demod_in,
  output logic                      demod_enable,
  // clocks for external converters
  output logic                      crystal_clock_out,
  output logic                      crystal_div2_out,
  output logic                      crystal_div4_out,
  // interrupt
  output logic                      irq
);
  import adf_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  logic [15:0]     demod_ctrl_reg;   // global enable, ext selects
  logic [15:0]     adc_cfg_reg;      // enables, rates, routing
  adf_bus_e        state_reg;        // bus data phase state
  adf_bus_e        state_next;
  adf_addr_s       addr_reg;         // captured address phase
  logic [31:0]     hrdata_reg;       // read data
  logic [EVT_W-1:0] irq_stat_reg;    // sticky events
  logic [EVT_W-1:0] irq_stat_next;
  logic [EVT_W-1:0] irq_mask_reg;    // event mask
  logic [7:0]      div_cnt_reg;      // crystal half period divider
  logic [2:0]      xphase_reg;       // crystal, /2, /4 phases
  logic [2:0]      ext_s1_reg;       // pin sync, first stage
  logic [2:0]      ext_s2_reg;       // pin sync, second stage
  logic [AD_OUT_W-1:0] samp_reg [3]; // left, right, mono samples
  logic [D6_W-1:0]     d6_reg [2];   // dec6 left, right samples

  // ************************************************************
  // field decode
  // ************************************************************
  wire       gen       = demod_ctrl_reg[BIT_GLOBAL_EN];
  wire       sel_l     = demod_ctrl_reg[BIT_EXT_LEFT];
  wire       sel_r     = demod_ctrl_reg[BIT_EXT_RIGHT];
  wire       sel_m     = demod_ctrl_reg[BIT_EXT_MONO];
  wire       swap      = adc_cfg_reg[BIT_SWAP23];
  wire [1:0] d6sel     = adc_cfg_reg[D6SEL_HI:D6SEL_LO];
  wire [1:0] mono_rate = adc_cfg_reg[MRATE_HI:MRATE_LO];
  wire [1:0] st_rate   = adc_cfg_reg[SRATE_HI:SRATE_LO];
  wire       d6_en     = adc_cfg_reg[BIT_D6_EN];
  wire       mono_en   = adc_cfg_reg[BIT_MONO_EN];
  wire       st_en     = adc_cfg_reg[BIT_STEREO_EN];

  assign demod_enable = gen;

  // ************************************************************
  // crystal divider and converter clocks
  // ************************************************************
  wire half_tick = div_cnt_reg == 8'(XTAL_DIV - 1);
  wire ad_tick   = half_tick && (xphase_reg[1:0] == 2'b11);

  // divider runs always so outside converters keep their clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_reg <= 8'h00;
      xphase_reg  <= 3'h0;
    end else begin
      div_cnt_reg <= half_tick ? 8'h00 : div_cnt_reg + 8'h01;
      if (half_tick) begin
        xphase_reg <= xphase_reg + 3'h1;
      end
    end
  end
  assign crystal_clock_out = xphase_reg[0];
  assign crystal_div2_out  = xphase_reg[1];
  assign crystal_div4_out  = xphase_reg[2];

  // ************************************************************
  // input routing
  // ************************************************************
  // pins are sampled twice before use; outside parts follow our clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1_reg <= 3'h0;
      ext_s2_reg <= 3'h0;
    end else begin
      ext_s1_reg <= {ext_digital_in_mono, ext_digital_in_right,
                     ext_digital_in_left};
      ext_s2_reg <= ext_s1_reg;
    end
  end

  wire left_path  = sel_l ? ext_s2_reg[0] : mod_bit_left;
  wire right_path = sel_r ? ext_s2_reg[1] : mod_bit_right;
  wire line3_path = sel_m ? ext_s2_reg[2] : third_line_input;
  logic [2:0] ad_bit;
  assign ad_bit[0] = left_path;
  assign ad_bit[1] = swap ? line3_path : right_path;
  assign ad_bit[2] = swap ? right_path : line3_path;

  // ************************************************************
  // ad filters
  // ************************************************************
  logic [AD_OUT_W-1:0] ad_out [3];
  logic [2:0]          ad_v;
  logic [9:0]          ad_ratio [3];
  logic [2:0]          ad_clr;
  assign ad_ratio[0] = decim_ratio(st_rate);
  assign ad_ratio[1] = decim_ratio(st_rate);
  assign ad_ratio[2] = decim_ratio(mono_rate);
  assign ad_clr[0]   = !gen || !st_en;
  assign ad_clr[1]   = !gen || !st_en;
  assign ad_clr[2]   = !gen || !mono_en;

  generate
    for (genvar i = 0; i < 3; i++) begin : g_ad
      adf_decim #(
        .IN_W (AD_IN_W),
        .OUT_W(AD_OUT_W),
        .CNT_W(AD_CNT_W)
      ) u_ad (
        .clk   (hclk),
        .rst_n (hresetn),
        .clear (ad_clr[i]),
        .ce    (ad_tick),
        .ratio (ad_ratio[i]),
        .din   (ad_bit[i] ? 2'sb01 : 2'sb11),
        .dout  (ad_out[i]),
        .dvalid(ad_v[i])
      );
    end
  endgenerate

  // ************************************************************
  // decimation-by-6 filter
  // ************************************************************
  logic [D6_W-1:0] d6_in [2];
  logic [D6_W-1:0] d6_out [2];
  logic [1:0]      d6_v;
  wire d6_clr = !gen || !d6_en;
  wire d6_ce  = (d6sel == D6SEL_DEMOD)  ? demod_in.valid :
                (d6sel == D6SEL_STEREO) ? ad_v[0] : ad_v[2];
  assign d6_in[0] = (d6sel == D6SEL_DEMOD)  ? demod_in.left :
                    (d6sel == D6SEL_STEREO) ? ad_out[0][AD_OUT_W-1 -: D6_W]
                                            : ad_out[2][AD_OUT_W-1 -: D6_W];
  assign d6_in[1] = (d6sel == D6SEL_DEMOD)  ? demod_in.right :
                    (d6sel == D6SEL_STEREO) ? ad_out[1][AD_OUT_W-1 -: D6_W]
                                            : ad_out[2][AD_OUT_W-1 -: D6_W];

  generate
    for (genvar j = 0; j < 2; j++) begin : g_d6
      adf_decim #(
        .IN_W (D6_W),
        .OUT_W(D6_W),
        .CNT_W(D6_CNT_W)
      ) u_d6 (
        .clk   (hclk),
        .rst_n (hresetn),
        .clear (d6_clr),
        .ce    (d6_ce),
        .ratio (D6_RATIO),
        .din   (d6_in[j]),
        .dout  (d6_out[j]),
        .dvalid(d6_v[j])
      );
    end
  endgenerate

  // ************************************************************
  // sample registers: hold last sample until replaced
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int k = 0; k < 3; k++) samp_reg[k] <= '0;
      for (int k = 0; k < 2; k++) d6_reg[k] <= '0;
    end else begin
      for (int k = 0; k < 3; k++) begin
        if (ad_v[k]) samp_reg[k] <= ad_out[k];
      end
      for (int k = 0; k < 2; k++) begin
        if (d6_v[0]) d6_reg[k] <= d6_out[k];
      end
    end
  end

  // ************************************************************
  // ahb-lite slave
  // ************************************************************
  wire addr_ok = hsel && htrans[1] && hready;
  wire wr_now  = state_reg == ADF_WR;
  wire rd_now  = state_reg == ADF_RD_WAIT;

  // next state: reads take one wait cycle, writes none
  always_comb begin
    case (state_reg)
      ADF_RD_WAIT: state_next = ADF_RD_DONE;
      ADF_IDLE, ADF_RD_DONE, ADF_WR:
        state_next = !addr_ok ? ADF_IDLE :
                     hwrite   ? ADF_WR   : ADF_RD_WAIT;
      default:     state_next = ADF_IDLE;
    endcase
  end

  // read mux, 16-bit words in the low half
  logic [15:0] rd_word;
  always_comb begin
    case (addr_reg.idx)
      IDX_DEMOD_CTRL: rd_word = demod_ctrl_reg;
      IDX_ADC_CFG:    rd_word = adc_cfg_reg;
      IDX_LEFT_LO:    rd_word = {samp_reg[0][7:0], 8'h00};
      IDX_LEFT_HI:    rd_word = samp_reg[0][23:8];
      IDX_RIGHT_LO:   rd_word = {samp_reg[1][7:0], 8'h00};
      IDX_RIGHT_HI:   rd_word = samp_reg[1][23:8];
      IDX_MONO_LO:    rd_word = {samp_reg[2][7:0], 8'h00};
      IDX_MONO_HI:    rd_word = samp_reg[2][23:8];
      IDX_D6L_LO:     rd_word = {d6_reg[0][1:0], 14'h0000};
      IDX_D6L_HI:     rd_word = d6_reg[0][17:2];
      IDX_D6R_LO:     rd_word = {d6_reg[1][1:0], 14'h0000};
      IDX_D6R_HI:     rd_word = d6_reg[1][17:2];
      IDX_IRQ_STAT:   rd_word = {13'h0000, irq_stat_reg};
      IDX_IRQ_MASK:   rd_word = {13'h0000, irq_mask_reg};
      default:        rd_word = 16'h0000;
    endcase
  end

  // events set, a status read clears; a new event wins
  wire stat_clr = rd_now && (addr_reg.idx == IDX_IRQ_STAT);
  wire [EVT_W-1:0] events = {d6_v[0], ad_v[2], ad_v[0]};
  assign irq_stat_next = (stat_clr ? '0 : irq_stat_reg) | events;

  // bus registers and writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg      <= ADF_IDLE;
      addr_reg       <= '0;
      hrdata_reg     <= 32'h0000_0000;
      demod_ctrl_reg <= CTRL_RESET;
      adc_cfg_reg    <= CFG_RESET;
      irq_stat_reg   <= '0;
      irq_mask_reg   <= '0;
    end else begin
      state_reg    <= state_next;
      irq_stat_reg <= irq_stat_next;
      if (addr_ok) addr_reg <= '{write: hwrite, idx: haddr[17:2]};
      if (rd_now) hrdata_reg <= {16'h0000, rd_word};
      if (wr_now && addr_reg.idx == IDX_DEMOD_CTRL)
        demod_ctrl_reg <= hwdata[15:0] & CTRL_WMASK;
      if (wr_now && addr_reg.idx == IDX_ADC_CFG)
        adc_cfg_reg <= hwdata[15:0] & CFG_WMASK;
      if (wr_now && addr_reg.idx == IDX_IRQ_MASK)
        irq_mask_reg <= hwdata[EVT_W-1:0];
    end
  end

  assign hreadyout = !rd_now;
  assign hrdata    = hrdata_reg;
  assign hresp     = HRESP_OKAY;
  assign irq       = |(irq_stat_reg & irq_mask_reg);

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic       aligned_reg;   // stereo and mono started together
  logic [9:0] gap_reg [2];   // ad ticks between outputs
  logic [1:0] full_reg;      // last gap spans a whole frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aligned_reg <= 1'b0;
      gap_reg[0]  <= 10'h000;
      gap_reg[1]  <= 10'h000;
      full_reg    <= 2'b00;
    end else begin
      aligned_reg <= !gen || (aligned_reg && st_en && mono_en &&
                     st_rate == mono_rate);
      for (int m = 0; m < 2; m++) begin
        gap_reg[m] <= ad_v[2*m] ? 10'h000 : gap_reg[m] + 10'(ad_tick);
      end
      // sampled functions take no loop index, so one line per filter
      full_reg[0] <= !ad_clr[0] && $stable(ad_ratio[0]) &&
                     (full_reg[0] || ad_v[0]);
      full_reg[1] <= !ad_clr[2] && $stable(ad_ratio[2]) &&
                     (full_reg[1] || ad_v[2]);
    end
  end

  sequence s_restart;
    !gen ##1 gen;
  endsequence
  sequence s_wr_cfg;
    wr_now && addr_reg.idx == IDX_ADC_CFG;
  endsequence

  glob_off_idle_a: assert property (!gen |=> !(|ad_v) && !d6_v[0])
    else $error("filter output while global enable low");
  phase_lock_a: assert property (aligned_reg && gen |->
    ad_v[0] == ad_v[2]) else $error("stereo and mono out of phase");
  restart_clear_a: assert property (s_restart |-> ##1 !ad_v[0])
    else $error("output right after restart");
  ext_route_a: assert property (sel_l && $past(sel_l, 2) |->
    ad_bit[0] == $past(ext_digital_in_left, 2))
    else $error("left external pin not routed");
  clock_rel_a: assert property ($rose(crystal_div4_out) |->
    !crystal_div2_out && !crystal_clock_out)
    else $error("crystal divide outputs out of step");
  irq_raise_a: assert property (ad_v[0] && irq_mask_reg[0] |=> irq)
    else $error("no interrupt after stereo sample");
  swap_route_a: assert property (swap && !sel_r |->
    ad_bit[2] == mod_bit_right) else $error("swap did not route");
  dec6_sel_a: assert property (d6sel[1] |-> d6_in[0] == d6_in[1] &&
    d6_ce == ad_v[2]) else $error("mono not fed to dec6");
  stereo_rate_a: assert property (ad_v[0] && full_reg[0] |->
    gap_reg[0] == decim_ratio(st_rate))
    else $error("stereo decimation factor wrong");
  mono_rate_a: assert property (ad_v[2] && full_reg[1] |->
    gap_reg[1] == decim_ratio(mono_rate))
    else $error("mono decimation factor wrong");
  dec6_off_a: assert property (!d6_en |=> !d6_v[0])
    else $error("dec6 output while disabled");
  enable_gate_a: assert property (!st_en && !mono_en |=>
    !ad_v[0] && !ad_v[2]) else $error("ad output while disabled");
  tick_space_a: assert property (ad_tick |=> !ad_tick [*3])
    else $error("ad input rate too fast");
  sample_load_a: assert property (ad_v[0] |=>
    samp_reg[0] == $past(ad_out[0])) else $error("sample not loaded");
  cfg_write_a: assert property (s_wr_cfg |=>
    adc_cfg_reg == ($past(hwdata[15:0]) & CFG_WMASK))
    else $error("config write lost");
  sample_hold_a: assert property (!ad_v[0] |=>
    $stable(samp_reg[0])) else $error("sample changed without new output");
endmodule : adf_ctrl

// [inc/adf_pkg.sv]
// adf_pkg: register map, field layout and types of the adc filter control
// assumes: included before every design file of the adf block
package adf_pkg;

  // ************************************************************
  // register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [15:0] IDX_DEMOD_CTRL = 16'hFE40; // global control
  localparam logic [15:0] IDX_ADC_CFG    = 16'hFE41; // filter config
  localparam logic [15:0] IDX_LEFT_LO    = 16'hFE46; // left bits 7:0
  localparam logic [15:0] IDX_LEFT_HI    = 16'hFE47; // left bits 23:8
  localparam logic [15:0] IDX_RIGHT_LO   = 16'hFE48; // right bits 7:0
  localparam logic [15:0] IDX_RIGHT_HI   = 16'hFE49; // right bits 23:8
  localparam logic [15:0] IDX_MONO_LO    = 16'hFE4A; // mono bits 7:0
  localparam logic [15:0] IDX_MONO_HI    = 16'hFE4B; // mono bits 23:8
  localparam logic [15:0] IDX_D6L_LO     = 16'hFE4E; // dec6 left 1:0
  localparam logic [15:0] IDX_D6L_HI     = 16'hFE4F; // dec6 left 17:2
  localparam logic [15:0] IDX_D6R_LO     = 16'hFE50; // dec6 right 1:0
  localparam logic [15:0] IDX_D6R_HI     = 16'hFE51; // dec6 right 17:2
  localparam logic [15:0] IDX_IRQ_STAT   = 16'hFE5C; // sticky events
  localparam logic [15:0] IDX_IRQ_MASK   = 16'hFE5D; // event mask

  // ************************************************************
  // reset values and writable bits
  // ************************************************************
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CFG_RESET  = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'h70FF; // 15, 11:8 reserved
  localparam logic [15:0] CFG_WMASK  = 16'h03FF; // 15:10 reserved

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int BIT_EXT_RIGHT  = 14; // ext_input_right_sel
  localparam int BIT_EXT_LEFT   = 13; // ext_input_left_sel
  localparam int BIT_EXT_MONO   = 12; // ext_input_mono_sel
  localparam int BIT_GLOBAL_EN  = 6;  // filter_global_enable
  localparam int BIT_SWAP23     = 9;  // swap_filter2_filter3
  localparam int D6SEL_HI       = 8;  // decim6_input_select
  localparam int D6SEL_LO       = 7;
  localparam int MRATE_HI       = 6;  // mono_rate_select
  localparam int MRATE_LO       = 5;
  localparam int SRATE_HI       = 4;  // stereo_rate_select
  localparam int SRATE_LO       = 3;
  localparam int BIT_D6_EN      = 2;  // decim6_enable
  localparam int BIT_MONO_EN    = 1;  // mono_filter_enable
  localparam int BIT_STEREO_EN  = 0;  // stereo_filter_enable

  // ************************************************************
  // data path sizes and ratios
  // ************************************************************
  localparam int AD_IN_W   = 2;   // +1/-1 from a modulator bit
  localparam int AD_OUT_W  = 24;
  localparam int AD_CNT_W  = 10;
  localparam int D6_W      = 18;
  localparam int D6_CNT_W  = 3;
  localparam int EVT_W     = 3;
  localparam int EVT_STEREO = 0;
  localparam int EVT_MONO   = 1;
  localparam int EVT_DEC6   = 2;
  localparam logic [9:0] RATIO_BASE = 10'h020; // code 00: decimate by 32
  localparam logic [2:0] D6_RATIO   = 3'h6;
  localparam logic [1:0] D6SEL_DEMOD  = 2'h0;
  localparam logic [1:0] D6SEL_STEREO = 2'h1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    ADF_IDLE    = 2'b00,
    ADF_RD_WAIT = 2'b01,
    ADF_RD_DONE = 2'b11,
    ADF_WR      = 2'b10
  } adf_bus_e;

  typedef struct packed {
    logic        write; // captured hwrite
    logic [15:0] idx;   // word index
  } adf_addr_s;

  typedef struct packed {
    logic [17:0] left;
    logic [17:0] right;
    logic        valid; // one-cycle pulse
  } adf_dec6_in_s;

  // decimation factor from a two-bit rate code: 32 << code
  function automatic logic [9:0] decim_ratio(input logic [1:0] code);
    decim_ratio = RATIO_BASE << code;
  endfunction : decim_ratio

endpackage : adf_pkg

// [verilog/adf_decim.sv]
// adf_decim: integrate-and-dump decimator, one channel
// assumes: ce is a one-cycle enable from the same clock, clear is sync
`timescale 1ns/1ps
module adf_decim #(
  parameter int IN_W  = 2,
  parameter int OUT_W = 24,
  parameter int CNT_W = 10
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // control
  input  wire logic                    clear,
  input  wire logic                    ce,
  input  wire logic        [CNT_W-1:0] ratio,
  // data
  input  wire logic signed [IN_W-1:0]  din,
  output logic signed      [OUT_W-1:0] dout,
  output logic                         dvalid
);
  localparam int ACC_W = IN_W + CNT_W;

  logic signed [ACC_W-1:0] acc_reg;  // running sum
  logic        [CNT_W-1:0] cnt_reg;  // input samples taken
  logic signed [ACC_W-1:0] sum;      // sum including this input
  logic signed [OUT_W-1:0] scaled;   // sum fitted to output width
  logic                    last;     // this input closes a frame

  assign sum  = acc_reg + ACC_W'(din);
  // >= keeps a lowered ratio from running the count past its end
  assign last = cnt_reg >= CNT_W'(ratio - 1'b1);

  // left-justify or take the top bits
  generate
    if (OUT_W >= ACC_W) begin : g_wide
      logic [OUT_W:0] padded; // one spare zero keeps the fill non-empty
      assign padded = {sum, {(OUT_W - ACC_W + 1){1'b0}}};
      assign scaled = padded[OUT_W:1];
    end else begin : g_narrow
      assign scaled = sum[ACC_W-1 -: OUT_W];
    end
  endgenerate

  // accumulate, dump one sample per frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= '0;
      cnt_reg <= '0;
      dout    <= '0;
      dvalid  <= 1'b0;
    end else if (clear) begin
      acc_reg <= '0;
      cnt_reg <= '0;
      dvalid  <= 1'b0;
    end else begin
      dvalid <= ce && last;
      if (ce && last) begin
        dout    <= scaled;
        acc_reg <= '0;
        cnt_reg <= '0;
      end else if (ce) begin
        acc_reg <= sum;
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
endmodule : adf_decim

// [tb/adf_src.sv]
// adf_src: source side model, modulator bits, pins, demod samples
// assumes: div2 is the crystal/2 output of the block
`timescale 1ns/1ps
module adf_src (
  input  wire logic             hclk,
  input  wire logic             div2,
  output logic [2:0]            mod, // left, right, line3
  output logic [2:0]            ext, // pins: left, right, mono
  output adf_pkg::adf_dec6_in_s dm
);
  import adf_pkg::*;
  logic [2:0] ext_q = 3'h0; // pin levels
  logic [2:0] cnt   = 3'h0; // demod sample spacing
  logic [2:0] step  = 3'h0; // pin pattern position
  logic       d2q   = 1'b0; // last crystal/2 level
  // left and right converters alike, line3 carries -1
  assign mod = 3'b011;
  assign ext = ext_q;
  // pins step once per crystal/2 period; left, right mostly low
  always_ff @(posedge hclk) begin
    d2q <= div2;
    if (div2 && !d2q) begin
      step  <= step + 3'h1;
      ext_q <= {step != 3'h0, step == 3'h5, step == 3'h0};
    end
  end
  always_ff @(posedge hclk) cnt <= cnt + 3'h1;
  assign dm = {18'h1_0000, 18'h0_0100, cnt == 3'h0};
endmodule : adf_src

// [tb/adf_ctrl_tb_top.sv]
// adf_ctrl_tb_top: self-checking bench of the adc filter control
// assumes: adf_pkg first; adf_src feeds the source side
`timescale 1ns/1ps
module adf_ctrl_tb_top;
  import adf_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, irq, hrdy, hresp, den;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize, mod, ext, xc, xv;
  adf_dec6_in_s dm;
  int          n_fail, samples_checked, cyc;
  // rows: index, write data, read back
  logic [47:0] regs [5] = '{48'hFE40_FFFF_70FF, 48'hFE41_FFFF_03FF,
    48'hFE42_FFFF_0000, 48'hFE41_0000_0000, 48'hFE40_0000_0000};
  // rows: control, config, sample index, expected sign
  logic [48:0] paths [6] = '{{48'h0040_0002_FE4B, 1'b1},
    {48'h0040_0202_FE4B, 1'b0}, {48'h1040_0002_FE4B, 1'b0},
    {48'h0040_0001_FE47, 1'b0}, {48'h2040_0001_FE47, 1'b1},
    {48'h4040_0001_FE49, 1'b1}};
  // rows: config, dec6 left high word, dec6 right high word
  logic [47:0] d6rows [2] = '{48'h0085_FEE0_0180, 48'h0106_FE80_FE80};
  adf_ctrl #(.XTAL_DIV(1)) adf_ctrl_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
    .hrdata(hrdata), .hresp(hresp), .mod_bit_left(mod[0]),
    .mod_bit_right(mod[1]), .third_line_input(mod[2]),
    .ext_digital_in_left(ext[0]), .ext_digital_in_right(ext[1]),
    .ext_digital_in_mono(ext[2]), .demod_in(dm), .demod_enable(den),
    .crystal_clock_out(xc[0]), .crystal_div2_out(xc[1]),
    .crystal_div4_out(xc[2]), .irq(irq));
  adf_src adf_src_i (.hclk(hclk), .div2(xc[1]), .mod(mod), .ext(ext),
    .dm(dm));
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // one ahb-lite single transfer, waits for the slave
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [15:0] d, output logic [31:0] q);
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= {14'h0, a, 2'h0};
    do @(posedge hclk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    do @(posedge hclk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask : bus
  // no sample before the ratio, one just after it
  task automatic rate(input int b, input int sh, input int c);
    bus(1, IDX_ADC_CFG, 16'h0, r);
    bus(0, IDX_IRQ_STAT, 16'h0, r);
    bus(1, IDX_ADC_CFG, 16'((1 << b) | (c << sh)), r);
    repeat ((128 << c) - 16) @(posedge hclk);
    bus(0, IDX_IRQ_STAT, 16'h0, r);
    chk("early", 0, 32'(r[b]));
    repeat (32) @(posedge hclk);
    bus(0, IDX_IRQ_STAT, 16'h0, r);
    chk("sample", 1, 32'(r[b]));
  endtask : rate
  task automatic print_verdict();
    if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    {hwrite, htrans, haddr, hwdata} = '0;
    hsel = 1'b1;
    hsize = 3'h2;
    hresetn = 1'b0;
    repeat (20) @(posedge hclk);
    chk("rst pins", 32'h0000_0040, {25'h0, hrdy, hresp, irq, den, xc});
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 2; i++) begin
      bus(0, 16'(IDX_DEMOD_CTRL + i), 16'h0, r);
      chk("reset", 0, r);
    end
    foreach (regs[i]) begin
      bus(1, regs[i][47:32], regs[i][31:16], r);
      bus(0, regs[i][47:32], 16'h0, r);
      chk("reg", {16'h0, regs[i][15:0]}, r);
    end
    bus(1, IDX_ADC_CFG, 16'h0001, r);
    repeat (300) @(posedge hclk);
    bus(0, IDX_IRQ_STAT, 16'h0, r);
    chk("held", 0, {30'h0, r[0], den});
    bus(1, IDX_DEMOD_CTRL, 16'h0040, r);
    @(posedge hclk);
    chk("run", 1, 32'(den));
    xv = xc;
    repeat (4) @(posedge hclk);
    chk("xtal", 32'({~xv[2], xv[1:0]}), 32'(xc));
    for (int c = 0; c < 4; c++) begin
      rate(0, SRATE_LO, c);
      rate(1, MRATE_LO, c);
    end
    bus(1, IDX_IRQ_MASK, 16'h0001, r);
    bus(1, IDX_ADC_CFG, 16'h0001, r);
    repeat (200) @(posedge hclk);
    chk("irq set", 1, 32'(irq));
    bus(0, IDX_IRQ_STAT, 16'h0, r);
    chk("irq clr", 0, 32'(irq));
    foreach (paths[i]) begin
      bus(1, IDX_DEMOD_CTRL, paths[i][48:33], r);
      bus(1, IDX_ADC_CFG, paths[i][32:17], r);
      repeat (300) @(posedge hclk);
      bus(0, paths[i][16:1], 16'h0, r);
      chk("sign", 32'(paths[i][0]), 32'(r[15]));
    end
    // restart with stereo and mono at one rate: outputs together
    bus(1, IDX_DEMOD_CTRL, 16'h0000, r);
    bus(1, IDX_ADC_CFG, 16'h0003, r);
    bus(1, IDX_DEMOD_CTRL, 16'h2040, r);
    bus(0, IDX_IRQ_STAT, 16'h0, r);
    repeat (140) @(posedge hclk);
    bus(0, IDX_IRQ_STAT, 16'h0, r);
    chk("phase", 3, 32'(r[1:0]));
    bus(1, IDX_ADC_CFG, 16'h0004, r);
    bus(0, IDX_IRQ_STAT, 16'h0, r);
    repeat (100) @(posedge hclk);
    bus(0, IDX_IRQ_STAT, 16'h0, r);
    chk("dec6 evt", 1, 32'(r[EVT_DEC6]));
    bus(0, IDX_D6L_HI, 16'h0, r);
    chk("dec6 hi", 32'h0000_3000, r);
    foreach (d6rows[i]) begin
      bus(1, IDX_ADC_CFG, 16'h0, r);
      bus(1, IDX_ADC_CFG, d6rows[i][47:32], r);
      repeat (900) @(posedge hclk);
      bus(0, IDX_D6L_HI, 16'h0, r);
      chk("dec6 l", {16'h0, d6rows[i][31:16]}, r);
      bus(0, IDX_D6R_HI, 16'h0, r);
      chk("dec6 r", {16'h0, d6rows[i][15:0]}, r);
    end
    print_verdict();
  end
endmodule : adf_ctrl_tb_top
